/* core/log_readout_cfg.svh */
// offsets, field positions, response codes and sizes of the log readout window
`ifndef LOG_READOUT_CFG_SVH
`define LOG_READOUT_CFG_SVH
`define REG_USER_LOG_STATE      16'h9e01
`define REG_USER_LOG_HDR_REQ    16'h9e02
`define REG_USER_LOG_SAMPLE_SEL 16'h9e03
`define REG_FAULT_HIST_IDX_SEL  16'h9e04
`define REG_FAULT_HIST_COUNT    16'h9e05
`define REG_FAULT_HIST_LOAD_REQ 16'h9e06
`define REG_FAULT_COUNT_REQ     16'h9e09
`define REG_READ_BUF_FIRST      16'h9e0c
`define BUF_DEPTH               32
`define HDR_WORDS               12
`define HIST_SLOTS              6
`define HIST_WORDS              24
`define FAULT_COUNT             29
`define LOG_CAPACITY_WORDS      16'hf900
`define CNT_FIRST_LSB           0
`define CNT_NUM_LSB             8
`define AXI_RESP_OKAY           2'b00
`define AXI_RESP_SLVERR         2'b10
`endif

/* core/log_readout_pkg.sv */
// types shared by the log readout window
package log_readout_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ADDR  = 2'b01,
        ST_DATA  = 2'b10
    } fetch_state_t;

    typedef enum logic [1:0] {
        LD_NONE   = 2'b00,
        LD_HEADER = 2'b01,
        LD_HIST   = 2'b10,
        LD_COUNTS = 2'b11
    } load_kind_t;

    typedef struct packed {
        logic [31:0] trig_time;
        logic [31:0] trig_date;
        logic [63:0] selection;
        logic [15:0] words_per_sample;
        logic [15:0] period_ms;
        logic [15:0] post_samples;
    } log_header_t;

    typedef struct packed {
        logic [31:0] date;
        logic [31:0] time_of_day;
    } stamp_t;
endpackage

/* core/log_readout_register_window.sv */
// axi4-lite register window for user log and fault history readout
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "log_readout_cfg.svh"

// Behaviour
// [RULE1] status reads 1 or 2 while waiting for trigger or capturing
// [RULE2] status reads 3 once capture done and log ready
// [RULE3] writing one to header request loads twelve header words at buffer start
// [RULE4] header words 0..3: trigger time high, low, date high, low
// [RULE5] selection words ordered 31..16, 15..0, 63..48, 47..32
// [RULE6] last header words: sample count, words per sample, period, post samples
// [RULE7] writing a sample number loads that sample's words into the buffer
// [RULE8] one 16-bit occurrence counter per fault bit 0 through 28
// [RULE9] count request low byte is first index, high byte is how many
// [RULE10] requested counters fill consecutive buffer words from the first
// [RULE11] each fault keeps date and time of six latest occurrences
// [RULE12] host selects fault index before accessing its history
// [RULE13] entry count returns 0 to 6 logged occurrences for selected fault
// [RULE14] writing one to history request copies selected history into buffer
// [RULE15] history load always fills six date/time pairs
// [RULE16] history oldest first, four words each: date hi, lo, time hi, lo
// [RULE17] host uses entry count to judge which slots are valid
// [RULE18] sample count is fixed log capacity divided by words per sample
// [RULE19] sample words placed upward from buffer start in parameter order
// [RULE20] host waits for completed status before reading header or samples
module log_readout_register_window
    import log_readout_pkg::*;
#(
    parameter int AW     = 18,
    parameter int FAULTS = `FAULT_COUNT,
    parameter int DEPTH  = `BUF_DEPTH
) (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [1:0]        capture_state,
    input  wire log_header_t       header_info,
    output logic [15:0]            log_rd_addr,
    input  wire logic [15:0]       log_rd_data,
    input  wire logic [FAULTS-1:0] fault_event,
    input  wire stamp_t            now_stamp
);
    localparam int IW = AW - 2;

    // ---- write channel capture; address and data may come in either order
    logic [IW-1:0] aw_idx;
    logic          aw_full;
    logic [15:0]   w_data;
    logic          w_full;
    wire           wr_fire = aw_full & w_full & ~s_axi_bvalid;
    // an unstrobed byte lane reads as zero rather than keeping stale bits
    wire  [15:0]   w_mask  = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    always_ff @(posedge clock) begin
        if (srst) begin
            aw_full       <= 1'b0;
            aw_idx        <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full       <= 1'b1;
            aw_idx        <= s_axi_awaddr[AW-1:2];
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_full       <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            w_full       <= 1'b0;
            w_data       <= 16'h0000;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata[15:0] & w_mask;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_full       <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // ---- write decode; only the five command/select registers accept writes
    wire wr_hdr    = wr_fire && aw_idx == IW'(`REG_USER_LOG_HDR_REQ);
    wire wr_sample = wr_fire && aw_idx == IW'(`REG_USER_LOG_SAMPLE_SEL);
    wire wr_index  = wr_fire && aw_idx == IW'(`REG_FAULT_HIST_IDX_SEL);
    wire wr_hist   = wr_fire && aw_idx == IW'(`REG_FAULT_HIST_LOAD_REQ);
    wire wr_count  = wr_fire && aw_idx == IW'(`REG_FAULT_COUNT_REQ);
    wire wr_known  = wr_hdr | wr_sample | wr_index | wr_hist | wr_count;

    always_ff @(posedge clock) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---- selected fault index, read back as written
    logic [15:0] fault_sel;
    always_ff @(posedge clock) begin
        if (srst) begin
            fault_sel <= 16'h0000;
        end else if (wr_index) begin
            fault_sel <= w_data; // [RULE12]
        end
    end
    // an out of range index reads back as written but selects nothing
    wire sel_ok = fault_sel < 16'(FAULTS);
    wire [4:0] sel = sel_ok ? fault_sel[4:0] : 5'h00;

    // ---- per fault counters and time stamp history
    logic [15:0] occ_count [FAULTS];
    logic [2:0]  entries   [FAULTS];
    stamp_t      hist      [FAULTS][`HIST_SLOTS];

    genvar f, s;
    generate
        for (f = 0; f < FAULTS; f++) begin : g_fault
            // saturate rather than wrap so a long-lived fault never reads low
            always_ff @(posedge clock) begin
                if (srst) begin
                    occ_count[f] <= 16'h0000;
                    entries[f]   <= 3'h0;
                end else if (fault_event[f]) begin
                    if (occ_count[f] != 16'hffff) begin
                        occ_count[f] <= occ_count[f] + 16'h0001; // [RULE8]
                    end
                    if (entries[f] != 3'(`HIST_SLOTS)) begin
                        entries[f] <= entries[f] + 3'h1; // [RULE13]
                    end
                end
            end
            // valid stamps fill from slot 0; when full the oldest drops out
            for (s = 0; s < `HIST_SLOTS; s++) begin : g_slot
                wire full = entries[f] == 3'(`HIST_SLOTS);
                always_ff @(posedge clock) begin
                    if (srst) begin
                        hist[f][s] <= '0;
                    end else if (fault_event[f]) begin
                        if (full) begin
                            if (s == `HIST_SLOTS - 1) begin
                                hist[f][s] <= now_stamp; // [RULE11]
                            end else begin
                                // modulo keeps the unused neighbour index in range
                                hist[f][s] <= hist[f][(s + 1) % `HIST_SLOTS];
                            end
                        end else if (entries[f] == 3'(s)) begin
                            hist[f][s] <= now_stamp; // [RULE11]
                        end
                    end
                end
            end
        end
    endgenerate

    // ---- header words, computed sample count
    wire [15:0] wps       = header_info.words_per_sample;
    wire [15:0] n_samples = (wps == 16'h0000) ? 16'h0000
                            : 16'(`LOG_CAPACITY_WORDS / wps); // [RULE18]
    wire [15:0] hdr_word [`HDR_WORDS];
    assign hdr_word[0]  = header_info.trig_time[31:16]; // [RULE4]
    assign hdr_word[1]  = header_info.trig_time[15:0];
    assign hdr_word[2]  = header_info.trig_date[31:16];
    assign hdr_word[3]  = header_info.trig_date[15:0];
    assign hdr_word[4]  = header_info.selection[31:16]; // [RULE5]
    assign hdr_word[5]  = header_info.selection[15:0];
    assign hdr_word[6]  = header_info.selection[63:48];
    assign hdr_word[7]  = header_info.selection[47:32];
    assign hdr_word[8]  = n_samples; // [RULE6]
    assign hdr_word[9]  = wps;
    assign hdr_word[10] = header_info.period_ms;
    assign hdr_word[11] = header_info.post_samples;

    // ---- fault count request fields
    logic [7:0] cnt_first;
    logic [7:0] cnt_num;
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_first <= 8'h00;
            cnt_num   <= 8'h00;
        end else if (wr_count) begin
            cnt_first <= w_data[`CNT_FIRST_LSB +: 8]; // [RULE9]
            cnt_num   <= w_data[`CNT_NUM_LSB +: 8];
        end
    end

    // bulk loads take effect one cycle after the write, from a stable request
    load_kind_t load_kind;
    always_ff @(posedge clock) begin
        if (srst) begin
            load_kind <= LD_NONE;
        end else if (wr_hdr && w_data == 16'h0001) begin
            load_kind <= LD_HEADER; // [RULE3]
        end else if (wr_hist && w_data == 16'h0001) begin
            load_kind <= LD_HIST; // [RULE14]
        end else if (wr_count) begin
            load_kind <= LD_COUNTS;
        end else begin
            load_kind <= LD_NONE;
        end
    end

    // ---- sample fetch from log storage, one word per two cycles
    fetch_state_t state;
    fetch_state_t next_state;
    logic [7:0]   fill_ptr;
    logic [7:0]   fill_len;
    wire          fetch_done = fill_ptr == fill_len;
    wire [15:0]   sample_base = 16'(w_data * wps);
    // samples wider than the buffer are cut; only the first words are seen
    wire [7:0]    wps_cap = (wps > 16'(DEPTH)) ? 8'(DEPTH) : wps[7:0];

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = ST_IDLE;
            ST_ADDR: next_state = fetch_done ? ST_IDLE : ST_DATA;
            ST_DATA: next_state = ST_ADDR;
            default: next_state = ST_IDLE;
        endcase
        // a new command aborts a running fetch
        if (wr_sample) begin
            next_state = ST_ADDR;
        end else if (load_kind != LD_NONE) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state       <= ST_IDLE;
            fill_ptr    <= 8'h00;
            fill_len    <= 8'h00;
            log_rd_addr <= 16'h0000;
        end else begin
            state <= next_state;
            if (wr_sample) begin
                fill_ptr    <= 8'h00;
                fill_len    <= wps_cap; // [RULE7]
                log_rd_addr <= sample_base;
            end else if (state == ST_DATA) begin
                fill_ptr    <= fill_ptr + 8'h01;
                log_rd_addr <= log_rd_addr + 16'h0001;
            end
        end
    end

    // ---- shared read buffer
    logic [15:0] buffer [DEPTH];
    genvar b;
    generate
        for (b = 0; b < DEPTH; b++) begin : g_buf
            localparam int SLOT = b / 4;
            localparam int PART = b % 4;
            wire [8:0]  c_idx  = 9'(cnt_first) + 9'(b);
            wire        c_ok   = 8'(b) < cnt_num && c_idx < 9'(FAULTS);
            wire [15:0] c_word = c_ok ? occ_count[c_idx[4:0]] : 16'h0000; // [RULE10]
            wire [63:0] stamp  = (b < `HIST_WORDS && sel_ok)
                                 ? hist[sel][SLOT % `HIST_SLOTS] : 64'h0;
            // unused slots are copied too; host checks the entry count
            wire [15:0] h_word = stamp[63 - 16*PART -: 16]; // [RULE16] [RULE15]
            wire [15:0] d_word = (b < `HDR_WORDS) ? hdr_word[b % `HDR_WORDS] : 16'h0000;
            logic [15:0] next_word;
            always_comb begin
                next_word = buffer[b];
                case (load_kind)
                    LD_HEADER: next_word = d_word; // [RULE3]
                    LD_HIST:   next_word = h_word; // [RULE14]
                    LD_COUNTS: next_word = c_word; // [RULE10]
                    default:   next_word = buffer[b];
                endcase
                if (wr_sample) begin
                    next_word = 16'h0000;
                end else if (state == ST_DATA && fill_ptr == 8'(b)) begin
                    next_word = log_rd_data; // [RULE19]
                end
            end
            always_ff @(posedge clock) begin
                if (srst) begin
                    buffer[b] <= 16'h0000;
                end else begin
                    buffer[b] <= next_word;
                end
            end
        end
    endgenerate

    // ---- read channel, one answer per request
    // unmapped and write-only addresses answer with an error and zero data
    wire [IW-1:0] r_idx   = s_axi_araddr[AW-1:2];
    wire [IW-1:0] r_off   = r_idx - IW'(`REG_READ_BUF_FIRST);
    wire          r_buf   = r_idx >= IW'(`REG_READ_BUF_FIRST) && r_off < IW'(DEPTH);
    wire          r_state = r_idx == IW'(`REG_USER_LOG_STATE);
    wire          r_sel   = r_idx == IW'(`REG_FAULT_HIST_IDX_SEL);
    wire          r_cnt   = r_idx == IW'(`REG_FAULT_HIST_COUNT);
    wire [15:0]   r_word  = r_buf   ? buffer[r_off[4:0]]
                          : r_state ? {14'h0000, capture_state} // [RULE1] [RULE2]
                          : r_sel   ? fault_sel
                          : r_cnt   ? (sel_ok ? {13'h0000, entries[sel]} : 16'h0000) // [RULE13]
                          : 16'h0000;
    wire          r_known = r_buf | r_state | r_sel | r_cnt;

    always_ff @(posedge clock) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, r_word};
            s_axi_rresp   <= r_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end
endmodule

/* verification/log_readout_window_properties.sv */
// concurrent checks on the log readout window bus ports
`timescale 1ns/100ps
`include "log_readout_cfg.svh"
module log_readout_window_properties #(
    parameter int AW = 18
) (
    input wire logic          clock,
    input wire logic          srst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic [1:0]    s_axi_rresp,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    input wire logic [1:0]    capture_state
);
    logic [AW-3:0] wr_idx;
    logic [AW-3:0] rd_idx;
    assign wr_idx = s_axi_awaddr[AW-1:2];
    assign rd_idx = s_axi_araddr[AW-1:2];
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    hdr_write_okay_a: assert property (wr_take ##0 (wr_idx == `REG_USER_LOG_HDR_REQ) |->
        ##[1:2] (s_axi_bvalid && s_axi_bresp == `AXI_RESP_OKAY)) else $error("header write resp");
    ro_write_err_a: assert property (wr_take ##0 (wr_idx == `REG_FAULT_HIST_COUNT) |->
        ##[1:2] (s_axi_bvalid && s_axi_bresp == `AXI_RESP_SLVERR)) else $error("ro write resp");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
    state_read_a: assert property (rd_take ##0 (rd_idx == `REG_USER_LOG_STATE)
        |=> s_axi_rdata == {30'h0, $past(capture_state)}) else $error("log state wrong");
    wo_read_err_a: assert property (rd_take ##0 (rd_idx == `REG_USER_LOG_HDR_REQ) |=>
        s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("wo read resp");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read half not zero");
endmodule

bind log_readout_register_window log_readout_window_properties #(.AW(AW)) props (
    .clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .capture_state);

/* verification/log_storage_model.sv */
// log storage model: synchronous read memory behind the sample fetch
`timescale 1ns/100ps
module log_storage_model #(
    parameter logic [15:0] SCRAMBLE = 16'h5a3c
) (
    input  wire logic        clock,
    input  wire logic [15:0] rd_addr,
    output logic      [15:0] rd_data
);
    // contents follow the address so every fetch is predictable; one cycle late like real ram
    always_ff @(posedge clock) begin
        rd_data <= rd_addr ^ SCRAMBLE;
    end
endmodule

/* verification/test_log_readout_register_window.sv */
// self-checking bench for the log readout register window
`timescale 1ns/100ps
`include "log_readout_cfg.svh"
module test_log_readout_register_window
    import log_readout_pkg::*;
;
    localparam logic [15:0] SCRAMBLE = 16'h5a3c;
    logic        clock, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, capture_state;
    logic [15:0] log_rd_addr, log_rd_data;
    logic [28:0] fault_event;
    log_header_t header_info;
    stamp_t      now_stamp;
    int          error_cnt, check_count, seq;
    int          cnt [29];
    logic [15:0] hist [29][$];

    log_readout_register_window dut (
        .clock, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .capture_state, .header_info, .log_rd_addr, .log_rd_data, .fault_event, .now_stamp);
    log_storage_model #(.SCRAMBLE(SCRAMBLE)) storage (
        .clock, .rd_addr(log_rd_addr), .rd_data(log_rd_data));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    // answers are taken at the rising edge that samples them; slave outputs are flops
    task automatic wr(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wrc(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
        logic [1:0] r;
        wr(idx, d, r);
        chk("write resp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rdc(input string name, input logic [15:0] idx, input logic [15:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk(name, {16'h0, exp}, d);
        chk("read resp", {30'h0, `AXI_RESP_OKAY}, {30'h0, r});
    endtask

    task automatic pulse(input int f, input int times);
        repeat (times) begin
            @(posedge clock);
            seq++;
            now_stamp <= '{date: {16'h0a0b, 16'(seq)}, time_of_day: {16'h0c0d, 16'(seq) ^ 16'h00ff}};
            fault_event <= 29'(1) << f;
            cnt[f]++;
            hist[f].push_back(16'(seq));
            if (hist[f].size() > `HIST_SLOTS)
                hist[f].pop_front();
            @(posedge clock);
            fault_event <= '0;
        end
    endtask

    task automatic t_status();
        for (int s = 1; s <= 3; s++) begin
            @(posedge clock);
            capture_state <= 2'(s);
            rdc("log state", `REG_USER_LOG_STATE, 16'(s));
        end
    endtask

    task automatic t_header();
        logic [15:0] e [12];
        e = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h4455, 16'h6677, 16'h0011, 16'h2233,
              `LOG_CAPACITY_WORDS / 16'h0004, 16'h0004, 16'h000a, 16'h0f90};
        wrc(`REG_USER_LOG_HDR_REQ, 16'h0001, `AXI_RESP_OKAY);
        for (int i = 0; i < `HDR_WORDS; i++)
            rdc("header word", 16'h9e0c + 16'(i),
                e[i]);
    endtask

    task automatic t_sample();
        wrc(`REG_USER_LOG_SAMPLE_SEL, 16'h0003, `AXI_RESP_OKAY);
        repeat (2 * 4 + 4) @(posedge clock);
        for (int k = 0; k < 5; k++)
            rdc("sample word", 16'h9e0c + 16'(k),
                (k < 4) ? ((16'h000c + 16'(k)) ^ SCRAMBLE) : 16'h0000);
    endtask

    task automatic t_counts();
        pulse(5, 8);
        pulse(1, 3);
        pulse(28, 1);
        wrc(`REG_FAULT_COUNT_REQ, 16'h1d00, `AXI_RESP_OKAY);
        for (int i = 0; i < `FAULT_COUNT; i++)
            rdc("fault count", 16'h9e0c + 16'(i), 16'(cnt[i]));
        wrc(`REG_FAULT_COUNT_REQ, 16'h0101, `AXI_RESP_OKAY);
        rdc("single count", 16'h9e0c, 16'(cnt[1]));
        wrc(`REG_FAULT_COUNT_REQ, 16'h021c, `AXI_RESP_OKAY);
        rdc("last count", 16'h9e0c, 16'(cnt[28]));
        rdc("past last count", 16'h9e0d, 16'h0000);
    endtask

    // fault 28 follows fault 5, so stale slots from the fuller history would show
    task automatic t_history();
        int f_list [4] = '{0, 1, 5, 28};
        foreach (f_list[j]) begin
            wrc(`REG_FAULT_HIST_IDX_SEL, 16'(f_list[j]), `AXI_RESP_OKAY);
            rdc("fault index", `REG_FAULT_HIST_IDX_SEL, 16'(f_list[j]));
            rdc("entry count", `REG_FAULT_HIST_COUNT,
                16'(hist[f_list[j]].size()));
            wrc(`REG_FAULT_HIST_LOAD_REQ, 16'h0001, `AXI_RESP_OKAY);
            for (int i = 0; i < `HIST_WORDS; i++) begin
                logic [15:0] n;
                logic [15:0] w [4];
                n = (i / 4 < hist[f_list[j]].size()) ? hist[f_list[j]][i / 4] : 16'h0000;
                w = '{16'h0a0b, n, 16'h0c0d, n ^ 16'h00ff};
                rdc("history word", 16'h9e0c + 16'(i),
                    (i / 4 < hist[f_list[j]].size()) ? w[i % 4] : 16'h0000);
            end
        end
    endtask

    task automatic t_errors();
        logic [31:0] d;
        logic [1:0]  r;
        rd(16'h9e07, d, r);
        chk("unmapped read resp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
        chk("unmapped read data", 32'h0, d);
        rd(`REG_USER_LOG_HDR_REQ, d, r);
        chk("write-only read resp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
        wrc(`REG_USER_LOG_STATE, 16'h0000, `AXI_RESP_SLVERR);
        wrc(`REG_FAULT_HIST_COUNT, 16'h0000, `AXI_RESP_SLVERR);
        rdc("count kept", `REG_FAULT_HIST_COUNT, 16'(hist[28].size()));
        wrc(`REG_USER_LOG_HDR_REQ, 16'h0002, `AXI_RESP_OKAY);
        rdc("buffer kept", 16'h9e0c, 16'h0a0b);
    endtask

    initial begin
        srst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        capture_state = 2'h1;
        fault_event = '0;
        now_stamp = '0;
        header_info = '{trig_time: 32'h1234_5678, trig_date: 32'h9abc_def0,
                        selection: 64'h0011_2233_4455_6677, words_per_sample: 16'h0004,
                        period_ms: 16'h000a, post_samples: 16'h0f90};
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        t_status();
        t_header();
        t_sample();
        t_counts();
        t_history();
        t_errors();
        report_and_stop();
    end

    // the whole run needs well under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule
